//--- word_load_consts.vh
`ifndef WORD_LOAD_CONSTS_VH
`define WORD_LOAD_CONSTS_VH

// Primary opcodes
`define OPC_WORD_ZERO 6'h20
`define OPC_WORD_ZERO_UPD 6'h21
`define OPC_EXTENDED 6'h1F

// Extended opcodes, instruction bits 21-30
`define XO_BYTE_REV 10'h216
`define XO_SIGN_EXT 10'h155
`define XO_SIGN_EXT_UPD 10'h175

// Field positions, LSB-0 numbering of the 32-bit word
`define FLD_OPC_HI 31
`define FLD_OPC_LO 26
`define FLD_TGT_HI 25
`define FLD_TGT_LO 21
`define FLD_BASE_HI 20
`define FLD_BASE_LO 16
`define FLD_IDX_HI 15
`define FLD_IDX_LO 11
`define FLD_XO_HI 10
`define FLD_XO_LO 1
`define FLD_FIXED 0
`define FLD_DISP_HI 15
`define FLD_DISP_LO 0

// Register number that means literal zero in address forms
`define ZERO_REG 5'h00

`endif

//--- load_decoder.v
`timescale 1ns/10ps
`include "word_load_consts.vh"

module load_decoder #(
    parameter IMPL64 = 1
) (
    // Instruction word
    input wire [31:0] instr,
    // Instruction class
    output wire in_group,
    output wire is_disp,
    output wire is_disp_upd,
    output wire is_brev,
    output wire is_sext,
    output wire is_sext_upd,
    // Exceptions
    output wire illegal,
    output wire invalid,
    // Fields
    output wire [4:0] target_reg_field,
    output wire [4:0] base_reg_field,
    output wire [4:0] index_reg_field,
    output wire [15:0] disp
);
    wire [5:0] opc;
    wire [9:0] xo;
    wire fixed_bit;
    wire ext;
    wire sext_any;
    wire x_form;

    // Field extraction
    assign opc = instr[`FLD_OPC_HI:`FLD_OPC_LO];
    assign xo = instr[`FLD_XO_HI:`FLD_XO_LO];
    assign fixed_bit = instr[`FLD_FIXED];
    assign target_reg_field = instr[`FLD_TGT_HI:`FLD_TGT_LO];
    assign base_reg_field = instr[`FLD_BASE_HI:`FLD_BASE_LO];
    assign index_reg_field = instr[`FLD_IDX_HI:`FLD_IDX_LO];
    assign disp = instr[`FLD_DISP_HI:`FLD_DISP_LO];

    // Opcode recognition; bit 31 is checked separately
    assign ext = (opc == `OPC_EXTENDED);
    assign is_disp = (opc == `OPC_WORD_ZERO);
    assign is_disp_upd = (opc == `OPC_WORD_ZERO_UPD);
    assign is_brev = ext && (xo == `XO_BYTE_REV);
    assign is_sext = ext && (xo == `XO_SIGN_EXT);
    assign is_sext_upd = ext && (xo == `XO_SIGN_EXT_UPD);
    assign x_form = is_brev || is_sext || is_sext_upd;
    assign sext_any = is_sext || is_sext_upd;
    assign in_group = is_disp || is_disp_upd || x_form;

    // Fixed bit set, or sign loads on a 32-bit build, are illegal
    assign illegal = (x_form && fixed_bit)
        || (sext_any && (IMPL64 == 0));

    // Update form that would clobber zero or its own target
    assign invalid = !illegal && is_sext_upd
        && (base_reg_field == `ZERO_REG
        || base_reg_field == target_reg_field);
endmodule

//--- load_formatter.v
`timescale 1ns/10ps

module load_formatter #(
    parameter XLEN = 64
) (
    // Word as fetched, storage byte 0 in bits 31:24
    input wire [31:0] word,
    // Mode
    input wire brev,
    input wire sext,
    // Value for the target register
    output wire [XLEN-1:0] result
);
    wire [31:0] reversed;
    wire [31:0] low;
    genvar i;

    // Byte lane swap, storage byte i lands in register byte 3-i
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_swap
            assign reversed[8*i+7:8*i] = word[31-8*i:24-8*i];
        end
    endgenerate

    assign low = brev ? reversed : word;

    // Upper half: sign copies or zeros
    generate
        if (XLEN > 32)
        begin : g_wide
            assign result = {{(XLEN-32){sext & low[31]}}, low};
        end
        else
        begin : g_narrow
            assign result = low;
        end
    endgenerate
endmodule

//--- word_load_unit.v
// Contract
// - Opcode 32 is plain word load; target 6-10, base 11-15, disp 16-31.
// - Opcode 33 is word load with update, same field layout.
// - Opcode 31, extended 534 is byte-reversed indexed word load.
// - Opcode 31, extended 341, bit 31 zero: sign-extending indexed load.
// - Opcode 31, extended 373, bit 31 zero: sign-extending update load.
// - Displacement is 16-bit signed, sign-extended before adding to base.
// - Displacement forms with base field zero use displacement alone.
// - Byte-reversed address is base plus index, index alone if base zero.
// - Sign-extending indexed address is base plus index, or index alone.
// - Sign-extending update address is always base plus index.
// - Sign update form invalid when base is zero or equals target.
// - Sign loads put word low and fill upper half with sign.
// - Sign loads are illegal on 32-bit builds.
// - Byte-reversed load swaps the four bytes end for end.
// - Displacement update writes address to base unless zero, target, fault.
// - These loads never touch fixed-point exception or condition flags.
`timescale 1ns/10ps
`include "word_load_consts.vh"

module word_load_unit #(
    parameter XLEN = 64,
    parameter IMPL64 = 1
) (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Instruction issue
    input wire ISSUE_VALID,
    input wire [31:0] ISSUE_INSTR,
    output wire ISSUE_READY,
    // Storage port
    output wire MEM_REQ,
    output wire [XLEN-1:0] MEM_ADDR,
    input wire MEM_ACK,
    input wire [31:0] MEM_RDATA,
    input wire MEM_ALIGN_ERR,
    input wire MEM_DSI_ERR,
    // Completion and exceptions
    output wire DONE,
    output wire NOT_IN_GROUP,
    output wire ILLEGAL,
    output wire INVALID_FORM,
    output wire FAULT,
    output wire FLAGS_WE,
    // Register file side port
    input wire GPR_WE,
    input wire [4:0] GPR_WADDR,
    input wire [XLEN-1:0] GPR_WDATA,
    input wire [4:0] GPR_RADDR,
    output wire [XLEN-1:0] GPR_RDATA
);
    // One load at a time: a single outstanding storage request keeps
    // ordering trivial and needs no tag logic, at the cost of one dead
    // cycle after every answer.
    // One-hot states
    localparam [2:0] S_IDLE = 3'h1;
    localparam [2:0] S_WAIT = 3'h2;
    localparam [2:0] S_DONE = 3'h4;

    // General purpose registers; no reset, software preloads them over the
    // side port. Register zero is a real register, only the address forms
    // read a zero base field as literal zero.
    reg [XLEN-1:0] gpr [0:31];

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg ready_reg;
    reg req_reg;
    reg [XLEN-1:0] addr_reg;
    reg done_reg;
    reg miss_reg;
    reg illegal_reg;
    reg invalid_reg;
    reg fault_reg;
    reg flags_we_reg;
    reg [XLEN-1:0] rdata_reg;
    reg [4:0] tgt_reg;
    reg [4:0] base_reg;
    reg brev_reg;
    reg sext_reg;
    reg upd_reg;

    wire in_group;
    wire is_disp;
    wire is_disp_upd;
    wire is_brev;
    wire is_sext;
    wire is_sext_upd;
    wire dec_illegal;
    wire dec_invalid;
    wire [4:0] target_reg_field;
    wire [4:0] base_reg_field;
    wire [4:0] index_reg_field;
    wire [15:0] disp;
    wire [XLEN-1:0] load_value;
    wire [XLEN-1:0] base_val;
    wire [XLEN-1:0] index_val;
    wire [XLEN-1:0] disp_ext;
    wire base_zero;
    wire take;
    wire launch;
    wire fault_now;
    wire upd_now;

    load_decoder #(
        .IMPL64(IMPL64)
    ) u_dec (
        .instr(ISSUE_INSTR),
        .in_group(in_group),
        .is_disp(is_disp),
        .is_disp_upd(is_disp_upd),
        .is_brev(is_brev),
        .is_sext(is_sext),
        .is_sext_upd(is_sext_upd),
        .illegal(dec_illegal),
        .invalid(dec_invalid),
        .target_reg_field(target_reg_field),
        .base_reg_field(base_reg_field),
        .index_reg_field(index_reg_field),
        .disp(disp)
    );

    load_formatter #(
        .XLEN(XLEN)
    ) u_fmt (
        .word(MEM_RDATA),
        .brev(brev_reg),
        .sext(sext_reg),
        .result(load_value)
    );

    // Operands come straight from the offered word, so the address is
    // ready in the take cycle and no extra pipeline stage is needed.
    // Operand fetch, combinational read of the register array
    assign base_val = gpr[base_reg_field];
    assign index_val = gpr[index_reg_field];
    assign base_zero = (base_reg_field == `ZERO_REG);

    // Displacement widened with its sign
    assign disp_ext = {{(XLEN-16){disp[15]}}, disp};

    // Issue handshake and what happens to the taken word
    assign take = ISSUE_VALID && ready_reg;
    assign launch = take && in_group && !dec_illegal && !dec_invalid;

    // Both fault kinds are treated alike: nothing is written, so the same
    // word can simply be offered again once the fault is serviced.
    // Storage answer classification
    assign fault_now = MEM_ALIGN_ERR || MEM_DSI_ERR;
    assign upd_now = upd_reg && !fault_now;

    // The sign update form never reads base as literal zero; its
    // zero-base encoding is refused as an invalid form anyway.
    // Effective address select
    reg [XLEN-1:0] ea;
    always @*
    begin
        ea = {XLEN{1'b0}};
        if (is_disp || is_disp_upd)
        begin
            if (base_zero)
                ea = disp_ext;
            else
                ea = base_val + disp_ext;
        end
        else if (is_sext_upd)
            ea = base_val + index_val;
        else if (is_brev || is_sext)
        begin
            if (base_zero)
                ea = index_val;
            else
                ea = base_val + index_val;
        end
    end

    // Rejected words never leave idle, so they may follow each other
    // back to back.
    // Next state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (launch)
                    state_next = S_WAIT;
            end
            S_WAIT:
            begin
                if (MEM_ACK)
                    state_next = S_DONE;
            end
            S_DONE:
                state_next = S_IDLE;
            default:
                state_next = S_IDLE;
        endcase
    end

    // Result and exception outputs are one-cycle pulses; the issuing side
    // must watch them in the cycle after the take or the answer.
    // Sequencing, storage request and result pulses
    always @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= S_IDLE;
            ready_reg <= 1'b0;
            req_reg <= 1'b0;
            addr_reg <= {XLEN{1'b0}};
            done_reg <= 1'b0;
            miss_reg <= 1'b0;
            illegal_reg <= 1'b0;
            invalid_reg <= 1'b0;
            fault_reg <= 1'b0;
            flags_we_reg <= 1'b0;
            tgt_reg <= 5'h00;
            base_reg <= 5'h00;
            brev_reg <= 1'b0;
            sext_reg <= 1'b0;
            upd_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // Ready only when idle and not about to leave it
            ready_reg <= (state_next == S_IDLE);
            done_reg <= 1'b0;
            miss_reg <= 1'b0;
            illegal_reg <= 1'b0;
            invalid_reg <= 1'b0;
            fault_reg <= 1'b0;
            // No flag side effects, ever
            flags_we_reg <= 1'b0;
            if (state_reg == S_IDLE && take)
            begin
                miss_reg <= !in_group;
                illegal_reg <= in_group && dec_illegal;
                invalid_reg <= dec_invalid;
            end
            if (launch)
            begin
                req_reg <= 1'b1;
                addr_reg <= ea;
                tgt_reg <= target_reg_field;
                base_reg <= base_reg_field;
                brev_reg <= is_brev;
                sext_reg <= is_sext || is_sext_upd;
                // Update only for a distinct, nonzero base
                upd_reg <= is_sext_upd
                    || (is_disp_upd && !base_zero
                    && base_reg_field != target_reg_field);
            end
            if (state_reg == S_WAIT && MEM_ACK)
            begin
                req_reg <= 1'b0;
                done_reg <= !fault_now;
                fault_reg <= fault_now;
            end
        end
    end

    // Side-port writes are refused while a load is in flight, so a
    // preload can never race the base update of a pending load.
    // Register array writes; load results beat the side port
    always @(posedge CLK)
    begin
        if (state_reg == S_WAIT && MEM_ACK && !fault_now)
        begin
            gpr[tgt_reg] <= load_value;
            if (upd_now)
                gpr[base_reg] <= addr_reg;
        end
        else if (GPR_WE && state_reg == S_IDLE)
            gpr[GPR_WADDR] <= GPR_WDATA;
    end

    // Registered to keep every top-level output on a flop
    // Side port readback, one cycle late
    always @(posedge CLK)
    begin
        if (RST)
            rdata_reg <= {XLEN{1'b0}};
        else
            rdata_reg <= gpr[GPR_RADDR];
    end

    // Flag write enable is a constant low flop: none of these loads
    // change the exception or condition flags.
    // Outputs straight from flops
    assign ISSUE_READY = ready_reg;
    assign MEM_REQ = req_reg;
    assign MEM_ADDR = addr_reg;
    assign DONE = done_reg;
    assign NOT_IN_GROUP = miss_reg;
    assign ILLEGAL = illegal_reg;
    assign INVALID_FORM = invalid_reg;
    assign FAULT = fault_reg;
    assign FLAGS_WE = flags_we_reg;
    assign GPR_RDATA = rdata_reg;
endmodule

//--- word_load_assertions.sv
`timescale 1ns/10ps
`include "word_load_consts.vh"

module word_load_assertions #(
    parameter XLEN = 64
) (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Issue and storage
    input wire ISSUE_VALID,
    input wire [31:0] ISSUE_INSTR,
    input wire ISSUE_READY,
    input wire MEM_REQ,
    input wire [XLEN-1:0] MEM_ADDR,
    input wire MEM_ACK,
    input wire MEM_ALIGN_ERR,
    input wire MEM_DSI_ERR,
    // Completion
    input wire DONE,
    input wire ILLEGAL,
    input wire INVALID_FORM,
    input wire FAULT,
    input wire FLAGS_WE
);
    // Fields of the offered word
    wire take = ISSUE_VALID && ISSUE_READY;
    wire [5:0] opc = ISSUE_INSTR[31:26];
    wire [9:0] xo = ISSUE_INSTR[10:1];
    wire [4:0] tgt = ISSUE_INSTR[25:21];
    wire [4:0] base = ISSUE_INSTR[20:16];
    wire dform = opc == `OPC_WORD_ZERO || opc == `OPC_WORD_ZERO_UPD;
    wire xop = take && opc == `OPC_EXTENDED && !ISSUE_INSTR[0];
    wire err = MEM_ALIGN_ERR || MEM_DSI_ERR;
    wire upd = xo == `XO_SIGN_EXT_UPD;
    wire grp = xo == `XO_BYTE_REV || xo == `XO_SIGN_EXT || upd;
    reg [15:0] disp_reg;

    // Displacement kept one cycle, the word may change after the take
    always @(posedge CLK)
        disp_reg <= ISSUE_INSTR[15:0];

    default clocking dc @(posedge CLK); endclocking
    default disable iff (RST);

    // Storage answer steps
    sequence ack_ok_s;
        MEM_REQ && MEM_ACK && !err;
    endsequence
    sequence ack_bad_s;
        MEM_REQ && MEM_ACK && err;
    endsequence

    flags_untouched_a: assert property (!FLAGS_WE)
        else $error("flag write enable seen");
    done_after_ack_a: assert property (ack_ok_s |=> DONE && !FAULT)
        else $error("missing done after good answer");
    fault_suppress_a: assert property (ack_bad_s |=> FAULT && !DONE)
        else $error("missing fault after bad answer");
    ready_return_a: assert property (ack_ok_s |=> !ISSUE_READY ##1 ISSUE_READY)
        else $error("ready not back two cycles after answer");
    req_hold_a: assert property (MEM_REQ && !MEM_ACK |=>
        MEM_REQ && $stable(MEM_ADDR)) else $error("request dropped early");
    disp_decode_a: assert property (take && dform |=> MEM_REQ)
        else $error("displacement load not started");
    disp_zero_a: assert property (take && dform && base == `ZERO_REG |=>
        MEM_ADDR == {{(XLEN-16){disp_reg[15]}}, disp_reg})
        else $error("wrong address from displacement");
    x_decode_a: assert property (xop && grp && !upd |=> MEM_REQ)
        else $error("indexed load not started");
    sext_upd_a: assert property (xop && upd && base != 0 && base != tgt
        |=> MEM_REQ) else $error("update load not started");
    invalid_form_a: assert property (xop && upd &&
        (base == 0 || base == tgt) |=> INVALID_FORM && !MEM_REQ)
        else $error("invalid form not refused");
    fixed_bit_a: assert property (take && opc == `OPC_EXTENDED && grp
        && ISSUE_INSTR[0] |=> ILLEGAL && !MEM_REQ)
        else $error("set fixed bit not refused");
endmodule

bind word_load_unit word_load_assertions #(.XLEN(XLEN)) chk_inst (
    .CLK(CLK), .RST(RST), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_INSTR(ISSUE_INSTR), .ISSUE_READY(ISSUE_READY),
    .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
    .MEM_ALIGN_ERR(MEM_ALIGN_ERR), .MEM_DSI_ERR(MEM_DSI_ERR),
    .DONE(DONE), .ILLEGAL(ILLEGAL), .INVALID_FORM(INVALID_FORM),
    .FAULT(FAULT), .FLAGS_WE(FLAGS_WE)
);

//--- storage_model.sv
`timescale 1ns/10ps

module storage_model (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Request and answer shaping
    input wire req,
    input wire [1:0] lat,
    input wire [1:0] err,
    input wire [31:0] word,
    // Answer
    output reg ack,
    output reg [31:0] rdata,
    output reg align_err,
    output reg dsi_err
);
    reg [1:0] wait_reg;

    // Answer after lat wait cycles; idle lines flip so stale data shows
    always @(posedge clk)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            wait_reg <= 2'h0;
            rdata <= 32'h0;
            {align_err, dsi_err} <= 2'h0;
        end
        else if (req && !ack && wait_reg == lat)
        begin
            ack <= 1'b1;
            rdata <= word;
            {align_err, dsi_err} <= err;
        end
        else
        begin
            ack <= 1'b0;
            wait_reg <= (req && !ack) ? wait_reg + 2'h1 : 2'h0;
            rdata <= ~rdata;
            {align_err, dsi_err} <= ~err;
        end
    end
endmodule

//--- test_word_load_unit.sv
`timescale 1ns/10ps
`include "word_load_consts.vh"

module test_word_load_unit;
    // Bench signals
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg valid = 1'b0;
    reg gwe = 1'b0;
    reg [31:0] instr = 32'h0;
    reg [31:0] word = 32'h0;
    reg [4:0] gwa = 5'h0;
    reg [4:0] gra = 5'h0;
    reg [63:0] gwd = 64'h0;
    reg [1:0] lat = 2'h0;
    reg [1:0] err = 2'h0;
    reg [2:0] kd;
    reg [4:0] t, b, x;
    wire ready, req, ack, aerr, derr, done, nig, ill, inv, flt, fwe;
    wire [63:0] addr, grd;
    wire [31:0] rdata;
    reg [63:0] gpr [0:31];
    integer err_total = 0;
    integer cmp_count = 0;
    integer i, k;

    always #20 clk = ~clk;

    word_load_unit word_load_unit_inst (
        .CLK(clk), .RST(rst), .ISSUE_VALID(valid), .ISSUE_INSTR(instr),
        .ISSUE_READY(ready), .MEM_REQ(req), .MEM_ADDR(addr), .MEM_ACK(ack),
        .MEM_RDATA(rdata), .MEM_ALIGN_ERR(aerr), .MEM_DSI_ERR(derr),
        .DONE(done), .NOT_IN_GROUP(nig), .ILLEGAL(ill),
        .INVALID_FORM(inv), .FAULT(flt), .FLAGS_WE(fwe), .GPR_WE(gwe),
        .GPR_WADDR(gwa), .GPR_WDATA(gwd), .GPR_RADDR(gra), .GPR_RDATA(grd)
    );
    storage_model storage_model_inst (
        .clk(clk), .rst(rst), .req(req), .lat(lat), .err(err), .word(word),
        .ack(ack), .rdata(rdata), .align_err(aerr), .dsi_err(derr)
    );

    task check(input [63:0] got, input [63:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected at %0t: %h, wanted %h", $time, got, exp);
        end
    end
    endtask

    task test_done;
    begin
        $display("mismatches %0d, compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    // Side-port readback, data one cycle after the address
    task rd(input [4:0] a, input [63:0] exp);
    begin
        @(posedge clk);
        gra <= a;
        @(posedge clk);
        #1 check(grd, exp);
    end
    endtask

    // Value the target should hold after a good load of w
    function [63:0] load_expect(input [2:0] kd, input [31:0] w);
    begin
        if (kd == 3'h2)
            load_expect = {32'h0, w[7:0], w[15:8], w[23:16], w[31:24]};
        else if (kd > 3'h2)
            load_expect = {{32{w[31]}}, w};
        else
            load_expect = {32'h0, w};
    end
    endfunction

    // Issue one word, await its outcome, then read target and base
    task op(input [2:0] kd, input [4:0] t, input [4:0] b, input [4:0] x,
            input [15:0] d);
        reg [63:0] ea, res, seen;
        reg [4:0] got, exp;
        reg [9:0] xo;
        reg [31:0] ins;
    begin
        xo = kd == 3'h2 || (kd == 3'h5 && d[0]) ? `XO_BYTE_REV :
             kd == 3'h3 || (kd == 3'h5 && d[1]) ? `XO_SIGN_EXT :
             `XO_SIGN_EXT_UPD;
        ins = kd < 3'h2 ? {kd[0] ? `OPC_WORD_ZERO_UPD : `OPC_WORD_ZERO,
              t, b, d} : kd == 3'h6 ? {6'h0E, t, b, d} :
              {`OPC_EXTENDED, t, b, x, xo, kd == 3'h5};
        ea = (b == 5'h0 && kd != 3'h4) ? 64'h0 : gpr[b];
        ea = ea + (kd < 3'h2 ? {{48{d[15]}}, d} : gpr[x]);
        res = load_expect(kd, word);
        exp = kd == 3'h7 ? 5'h01 : kd == 3'h6 ? 5'h04 : kd == 3'h5 ? 5'h02
              : err != 2'h0 ? 5'h08 : 5'h10;
        seen = ~ea;
        @(posedge clk);
        valid <= 1'b1;
        instr <= ins;
        @(posedge clk);
        valid <= 1'b0;
        got = 5'h0;
        // Rejections pulse right after the take edge, so look there first
        for (k = 0; k < 20 && got == 5'h0; k = k + 1)
        begin
            #1 if (req) seen = addr;
            got = {done, flt, nig, ill, inv};
            if (got == 5'h0)
                @(posedge clk);
        end
        check(got, exp);
        if (kd < 3'h5) check(seen, ea);
        if (exp == 5'h10)
        begin
            gpr[t] = res;
            if (kd == 3'h4 || (kd == 3'h1 && b != 5'h0 && b != t))
                gpr[b] = ea;
        end
        rd(t, gpr[t]);
        rd(b, gpr[b]);
    end
    endtask

    initial
    begin
        i = $urandom(19);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Preload, register zero nonzero so literal zero is visible
        for (i = 0; i < 32; i = i + 1)
        begin
            @(posedge clk);
            gpr[i] = {$urandom, $urandom};
            gwe <= 1'b1;
            gwa <= i[4:0];
            gwd <= gpr[i];
        end
        @(posedge clk);
        gwe <= 1'b0;
        // Corner cases first
        word = 32'h8001_02FF;
        op(3'h0, 5'h03, 5'h00, 5'h00, 16'h8000);
        op(3'h1, 5'h04, 5'h04, 5'h00, 16'h7FFC);
        op(3'h1, 5'h06, 5'h00, 5'h00, 16'hFFF0);
        op(3'h2, 5'h07, 5'h00, 5'h09, 16'h0000);
        op(3'h3, 5'h08, 5'h00, 5'h0A, 16'h0000);
        op(3'h7, 5'h09, 5'h00, 5'h03, 16'h0000);
        op(3'h7, 5'h09, 5'h09, 5'h03, 16'h0000);
        lat = 2'h3;
        err = 2'h1;
        op(3'h1, 5'h0B, 5'h0C, 5'h00, 16'h0010);
        err = 2'h2;
        op(3'h4, 5'h0D, 5'h0E, 5'h0F, 16'h0000);
        // Random mix of every kind, answer delay and fault
        for (i = 0; i < 80; i = i + 1)
        begin
            word = $urandom;
            lat = $urandom;
            err = ($urandom % 8 == 0) ? $urandom % 3 + 1 : 0;
            kd = $urandom;
            t = $urandom;
            b = $urandom;
            x = $urandom;
            if (kd == 3'h4 && (b == 5'h0 || b == t))
                b = t == 5'h1F ? 5'h01 : t + 5'h01;
            if (kd == 3'h7)
                b = $urandom % 2 ? 5'h00 : t;
            op(kd, t, b, x, $urandom);
        end
        test_done;
    end

    // Hang guard, far beyond the expected run length
    initial
    begin
        #400000;
        err_total = err_total + 1;
        test_done;
    end
endmodule
